// file: rtl/irq_flags_pkg.sv
/*
  Constants, field positions, reset values and carrier types for the
  peripheral interrupt enable and request-flag block.
  Assumes a single 250 MHz system clock and a plain register port with
  8-bit data; software sits on the same clock as this block.
*/
package irq_flags_pkg;

  // =========================================================================
  // register map (byte index on the 5-bit register port)
  localparam logic [4:0] ADDR_CTRL      = 5'h00;
  localparam logic [4:0] ADDR_EN0       = 5'h01;
  localparam logic [4:0] ADDR_EN2       = 5'h02;
  localparam logic [4:0] ADDR_EN3       = 5'h03;
  localparam logic [4:0] ADDR_EN4       = 5'h04;
  localparam logic [4:0] ADDR_REQ0      = 5'h05;
  localparam logic [4:0] ADDR_REQ2      = 5'h06;
  localparam logic [2:0] PAGE_RISE      = 3'h2;   // 0x08..0x0A, one per port
  localparam logic [2:0] PAGE_FALL      = 3'h3;   // 0x0C..0x0E
  localparam logic [2:0] PAGE_PINFLAG   = 3'h4;   // 0x10..0x12

  // =========================================================================
  // field positions
  localparam int BIT_GLOBAL_EN  = 7;
  localparam int BIT_PERIPH_EN  = 6;
  localparam int BIT_EDGE_SEL   = 0;
  localparam int BIT_TIMER0     = 5;
  localparam int BIT_PIN_CHANGE = 4;
  localparam int BIT_EXT_PIN    = 0;

  // implemented-bit masks
  localparam logic [7:0] CTRL_MASK = 8'hC1;
  localparam logic [7:0] REQ0_MASK = 8'h31;   // bits 7..6 and 3..1 absent
  localparam logic [7:0] REQ0_WMASK = 8'h21;  // summary bit is read-only

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h01;  // edge select comes up rising
  localparam logic [7:0] REG_RESET  = 8'h00;

  localparam int PORT_COUNT = 3;

  // =========================================================================
  // carrier for one register-port cycle
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef logic [PORT_COUNT-1:0][7:0] port_bits_type;

endpackage

// file: rtl/peripheral_irq_enable_flags.sv
/*
  Interrupt enable registers, request flags, pin-change detection and the
  combined interrupt request of a small microcontroller.
  Assumes: register port on clk_i, read data one cycle after the strobe;
  timer0 overflow and register-2 events are one-cycle pulses on clk_i;
  register-3/4 request levels come from peripheral flag registers on clk_i;
  the external pin and port pins are asynchronous and are synchronised here.
*/
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/10ps

module peripheral_irq_enable_flags
  import irq_flags_pkg::*;
(
  input  wire logic          clk_i,          // 250 MHz system clock
  input  wire logic          rstn_i,         // async reset, active low
  input  wire reg_req_type   bus_i,          // register port request
  output logic [7:0]         rdata_o,        // read data, cycle after strobe
  input  wire logic          timer0_ovf_i,   // timer0 overflow pulse
  input  wire logic          ext_pin_i,      // external interrupt pin
  input  wire port_bits_type port_pins_i,    // ports A..C pin levels
  input  wire logic [7:0]    req2_events_i,  // register-2 source pulses
  input  wire logic [7:0]    req3_flags_i,   // register-3 source flags
  input  wire logic [7:0]    req4_flags_i,   // register-4 source flags
  output logic               irq_o           // combined interrupt request
);

  // =========================================================================
  // helpers

  // flag update: a write loads the written value, hardware sets on top so
  // an event in the clearing cycle survives
  function automatic logic [7:0] flag_update(input logic [7:0] cur,
                                             input logic [7:0] set,
                                             input logic       we,
                                             input logic [7:0] wd,
                                             input logic [7:0] wmask);
    logic [7:0] base;
    base = we ? ((cur & ~wmask) | (wd & wmask)) : cur;
    return base | set;
  endfunction

  // true when the request hits one of the per-port pages
  function automatic logic page_hit(input logic [4:0] addr, input logic [2:0] page);
    return (addr[4:2] == page) && (addr[1:0] != 2'h3);
  endfunction

  // =========================================================================
  // state
  logic [7:0]    ctrl;
  logic [7:0]    en0;
  logic [7:0]    en2;
  logic [7:0]    en3;
  logic [7:0]    en4;
  logic [7:0]    req0;
  logic [7:0]    req2;
  port_bits_type rise_mask;
  port_bits_type fall_mask;
  port_bits_type pin_flags;

  logic [7:0]    next_ctrl;
  logic [7:0]    next_en0;
  logic [7:0]    next_en2;
  logic [7:0]    next_en3;
  logic [7:0]    next_en4;
  logic [7:0]    next_req0;
  logic [7:0]    next_req2;
  port_bits_type next_rise_mask;
  port_bits_type next_fall_mask;
  port_bits_type next_pin_flags;

  logic          ext_sync1;
  logic          ext_sync2;
  logic          ext_prev;
  port_bits_type pin_sync1;
  port_bits_type pin_sync2;
  port_bits_type pin_prev;

  logic [7:0]    next_rdata;
  logic          next_irq;

  logic          ext_hit;
  port_bits_type pin_hit;
  logic          summary;
  logic [1:0]    port_idx;

  // =========================================================================
  // synchronisers: first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_sync1 <= 1'h0;
      ext_sync2 <= 1'h0;
      ext_prev  <= 1'h0;
      pin_sync1 <= '0;
      pin_sync2 <= '0;
      pin_prev  <= '0;
    end else begin
      ext_sync1 <= ext_pin_i;
      ext_sync2 <= ext_sync1;
      ext_prev  <= ext_sync2;
      pin_sync1 <= port_pins_i;
      pin_sync2 <= pin_sync1;
      pin_prev  <= pin_sync2;
    end
  end

  // edge qualification; a pin high at reset release shows one rising edge
  always_comb begin
    ext_hit = ctrl[BIT_EDGE_SEL] ? (ext_sync2 & ~ext_prev)
                                 : (~ext_sync2 & ext_prev);
    for (int p = 0; p < PORT_COUNT; p++) begin
      pin_hit[p] = (pin_sync2[p] & ~pin_prev[p] & rise_mask[p])
                 | (~pin_sync2[p] & pin_prev[p] & fall_mask[p]);
    end
    summary = |pin_flags;
  end

  // =========================================================================
  // register writes and hardware flag setting
  always_comb begin
    next_ctrl      = ctrl;
    next_en0       = en0;
    next_en2       = en2;
    next_en3       = en3;
    next_en4       = en4;
    next_rise_mask = rise_mask;
    next_fall_mask = fall_mask;
    port_idx       = bus_i.addr[1:0];
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        ADDR_CTRL: next_ctrl = bus_i.wdata & CTRL_MASK;
        ADDR_EN0:  next_en0  = bus_i.wdata & REQ0_MASK;
        ADDR_EN2:  next_en2  = bus_i.wdata;
        ADDR_EN3:  next_en3  = bus_i.wdata;
        ADDR_EN4:  next_en4  = bus_i.wdata;
        default: begin
          if (page_hit(bus_i.addr, PAGE_RISE)) begin
            next_rise_mask[port_idx] = bus_i.wdata;
          end
          if (page_hit(bus_i.addr, PAGE_FALL)) begin
            next_fall_mask[port_idx] = bus_i.wdata;
          end
        end
      endcase
    end
    // flags set irrespective of any enable bit
    next_req0 = flag_update(req0,
                            {2'h0, timer0_ovf_i, 4'h0, ext_hit},
                            bus_i.wr && (bus_i.addr == ADDR_REQ0),
                            bus_i.wdata, REQ0_WMASK) & REQ0_WMASK;
    next_req2 = flag_update(req2, req2_events_i,
                            bus_i.wr && (bus_i.addr == ADDR_REQ2),
                            bus_i.wdata, 8'hFF);
    for (int p = 0; p < PORT_COUNT; p++) begin
      next_pin_flags[p] = flag_update(pin_flags[p], pin_hit[p],
                                      bus_i.wr && page_hit(bus_i.addr, PAGE_PINFLAG)
                                        && (port_idx == 2'(p)),
                                      bus_i.wdata, 8'hFF);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl      <= CTRL_RESET;
      en0       <= REG_RESET;
      en2       <= REG_RESET;
      en3       <= REG_RESET;
      en4       <= REG_RESET;
      req0      <= REG_RESET;
      req2      <= REG_RESET;
      rise_mask <= '0;
      fall_mask <= '0;
      pin_flags <= '0;
    end else begin
      ctrl      <= next_ctrl;
      en0       <= next_en0;
      en2       <= next_en2;
      en3       <= next_en3;
      en4       <= next_en4;
      req0      <= next_req0;
      req2      <= next_req2;
      rise_mask <= next_rise_mask;
      fall_mask <= next_fall_mask;
      pin_flags <= next_pin_flags;
    end
  end

  // =========================================================================
  // read data and combined request
  always_comb begin
    next_rdata = 8'h00;  // also the answer to unmapped addresses
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        ADDR_CTRL: next_rdata = ctrl;
        ADDR_EN0:  next_rdata = en0;
        ADDR_EN2:  next_rdata = en2;
        ADDR_EN3:  next_rdata = en3;
        ADDR_EN4:  next_rdata = en4;
        ADDR_REQ0: next_rdata = (req0 & REQ0_WMASK)
                              | {3'h0, summary, 4'h0};
        ADDR_REQ2: next_rdata = req2;
        default: begin
          if (page_hit(bus_i.addr, PAGE_RISE)) begin
            next_rdata = rise_mask[bus_i.addr[1:0]];
          end else if (page_hit(bus_i.addr, PAGE_FALL)) begin
            next_rdata = fall_mask[bus_i.addr[1:0]];
          end else if (page_hit(bus_i.addr, PAGE_PINFLAG)) begin
            next_rdata = pin_flags[bus_i.addr[1:0]];
          end
        end
      endcase
    end
    // core sources need only the global enable; the rest also need peripheral enable
    next_irq = ctrl[BIT_GLOBAL_EN]
             & ( (|(en0 & ((req0 & REQ0_WMASK) | {3'h0, summary, 4'h0})))
               | (ctrl[BIT_PERIPH_EN]
                  & (|(en2 & req2) | |(en3 & req3_flags_i) | |(en4 & req4_flags_i))) );
  end

  // registered outputs; a stale flag fires as soon as its enable is set
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
      irq_o   <= 1'h0;
    end else begin
      rdata_o <= next_rdata;
      irq_o   <= next_irq;
    end
  end

  // =========================================================================
  // checks
  a_timer0_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
    timer0_ovf_i |=> req0[BIT_TIMER0])
    else $error("timer0 overflow did not set its flag");

  a_timer0_holds: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (req0[BIT_TIMER0] && !(bus_i.wr && bus_i.addr == ADDR_REQ0)) |=> req0[BIT_TIMER0])
    else $error("timer0 flag dropped without a write");

  a_ext_edge_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ($rose(ext_sync2) && ctrl[BIT_EDGE_SEL]) |=> req0[BIT_EXT_PIN])
    else $error("rising external edge did not set flag");

  a_ext_wrong_edge: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ($rose(ext_sync2) && !ctrl[BIT_EDGE_SEL] && !req0[BIT_EXT_PIN]
     && !bus_i.wr) |=> !req0[BIT_EXT_PIN])
    else $error("falling-edge select fired on a rise");

  a_summary_read: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (bus_i.rd && bus_i.addr == ADDR_REQ0) |=> (rdata_o[BIT_PIN_CHANGE] == $past(|pin_flags)))
    else $error("summary bit does not follow pin flags");

  a_reserved_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (bus_i.rd && bus_i.addr == ADDR_REQ0) |=> (rdata_o[7:6] == 2'h0 && rdata_o[3:1] == 3'h0))
    else $error("unimplemented request bits read nonzero");

  a_flag_ignores_en: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (req2_events_i[0] && !en2[0] && !ctrl[BIT_GLOBAL_EN]) |=> req2[0])
    else $error("disabled source did not set its flag");

  a_en2_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (bus_i.wr && bus_i.addr == ADDR_EN2) |=> (en2 == $past(bus_i.wdata)))
    else $error("enable register 2 write lost");

  a_global_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !ctrl[BIT_GLOBAL_EN] |=> !irq_o)
    else $error("interrupt raised with global enable clear");

  a_periph_request: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ctrl[BIT_GLOBAL_EN] && ctrl[BIT_PERIPH_EN] && |(en4 & req4_flags_i)) |=> irq_o)
    else $error("enabled peripheral request not raised");

  a_rise_masked: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ($rose(pin_sync2[0][1]) && !rise_mask[0][1] && !pin_flags[0][1] && !bus_i.wr)
      |=> !pin_flags[0][1])
    else $error("masked rising pin edge set a flag");

  // enable writes, then flag setting, holding and clearing, grouped by source
  a_en3_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (bus_i.wr && bus_i.addr == ADDR_EN3) |=> (en3 == $past(bus_i.wdata)))
    else $error("enable register 3 write lost");

  a_en4_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (bus_i.wr && bus_i.addr == ADDR_EN4) |=> (en4 == $past(bus_i.wdata)))
    else $error("enable register 4 write lost");

  a_en0_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (bus_i.wr && bus_i.addr == ADDR_EN0) |=> (en0 == ($past(bus_i.wdata) & REQ0_MASK)))
    else $error("enable register 0 write wrong");

  a_ext_fall_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ($fell(ext_sync2) && !ctrl[BIT_EDGE_SEL]) |=> req0[BIT_EXT_PIN])
    else $error("falling external edge did not set flag");

  a_ext_holds: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (req0[BIT_EXT_PIN] && !(bus_i.wr && bus_i.addr == ADDR_REQ0)) |=> req0[BIT_EXT_PIN])
    else $error("external flag dropped without a write");

  a_timer0_clears: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (bus_i.wr && bus_i.addr == ADDR_REQ0 && !bus_i.wdata[BIT_TIMER0] && !timer0_ovf_i)
      |=> !req0[BIT_TIMER0])
    else $error("timer0 flag not cleared by a zero write");

  a_req2_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (|req2_events_i) |=> ((req2 & $past(req2_events_i)) == $past(req2_events_i)))
    else $error("register-2 event did not set its flag");

  a_req2_holds: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !(bus_i.wr && bus_i.addr == ADDR_REQ2) |=> ((req2 & $past(req2)) == $past(req2)))
    else $error("register-2 flag dropped without a write");

  a_pin_rise_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ($rose(pin_sync2[0][0]) && rise_mask[0][0]) |=> pin_flags[0][0])
    else $error("enabled rising pin edge did not set flag");

  a_pin_fall_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ($fell(pin_sync2[1][7]) && fall_mask[1][7]) |=> pin_flags[1][7])
    else $error("enabled falling pin edge did not set flag");

  a_pin_flag_holds: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (pin_flags[1][7] && !bus_i.wr) |=> pin_flags[1][7])
    else $error("pin change flag dropped without a write");

  // routing: an enabled and gated flag must reach irq_o one cycle later, and a clear peripheral enable must block the peripheral flags
  a_periph_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!ctrl[BIT_PERIPH_EN] && !(|(en0 & req0)) && !(en0[BIT_PIN_CHANGE] && |pin_flags)) |=> !irq_o)
    else $error("peripheral request passed a clear peripheral enable");

  a_core_request: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ctrl[BIT_GLOBAL_EN] && en0[BIT_TIMER0] && req0[BIT_TIMER0]) |=> irq_o)
    else $error("enabled timer0 request not raised");

  a_summary_irq: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ctrl[BIT_GLOBAL_EN] && en0[BIT_PIN_CHANGE] && |pin_flags) |=> irq_o)
    else $error("enabled pin change request not raised");

  a_req2_request: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ctrl[BIT_GLOBAL_EN] && ctrl[BIT_PERIPH_EN] && |(en2 & req2)) |=> irq_o)
    else $error("enabled register-2 request not raised");

  a_req3_request: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ctrl[BIT_GLOBAL_EN] && ctrl[BIT_PERIPH_EN] && |(en3 & req3_flags_i)) |=> irq_o)
    else $error("enabled register-3 request not raised");

endmodule // peripheral_irq_enable_flags

// file: tb/periph_model.sv
/*
  Peripheral-side model: timer0 and register-2 event pulses, register-3/4
  source levels, external pin and port pin levels.
  Assumes the bench calls its tasks; every change follows a rising clk_i.
*/
`timescale 1ns/10ps

module periph_model
  import irq_flags_pkg::*;
(
  input  wire logic     clk_i,      // system clock
  output logic          t0_ovf_o,   // timer0 overflow pulse
  output logic          ext_pin_o,  // external pin level
  output port_bits_type pins_o,     // port A..C pin levels
  output logic [7:0]    ev2_o,      // register-2 event pulses
  output logic [7:0]    lvl3_o,     // register-3 source levels
  output logic [7:0]    lvl4_o      // register-4 source levels
);
  // =========================================================================
  // quiet sources at time zero
  initial begin
    t0_ovf_o  = 1'h0;
    ext_pin_o = 1'h0;
    pins_o    = '0;
    ev2_o     = 8'h00;
    lvl3_o    = 8'h00;
    lvl4_o    = 8'h00;
  end

  // events last exactly one cycle, a longer pulse would hide a re-set bug
  task automatic pulse(input logic t0, input logic [7:0] ev);
    @(posedge clk_i);
    t0_ovf_o <= t0;
    ev2_o    <= ev;
    @(posedge clk_i);
    t0_ovf_o <= 1'h0;
    ev2_o    <= 8'h00;
  endtask

  // levels are held until the next call
  task automatic drive(input logic e, input port_bits_type p, input logic [7:0] l3, input logic [7:0] l4);
    @(posedge clk_i);
    ext_pin_o <= e;
    pins_o    <= p;
    lvl3_o    <= l3;
    lvl4_o    <= l4;
  endtask
endmodule // periph_model

// file: tb/peripheral_irq_enable_flags_bench.sv
/*
  Self-checking bench for the interrupt enable and request-flag block.
  Assumes the peripheral model drives every source input of the block.
*/
`timescale 1ns/10ps

module peripheral_irq_enable_flags_bench import irq_flags_pkg::*;;
  logic          clk;           // system clock
  logic          rstn;          // reset, active low
  reg_req_type   bus;           // register port request
  logic [7:0]    rdata;         // read data
  logic          irq;           // combined request
  logic          t0, ext;       // model pulse and pin
  port_bits_type pins;          // model port pins
  logic [7:0]    ev2, lv3, lv4; // model sources
  int            mismatches, total_checks, cycles;
  logic          ext_s, t0b;
  port_bits_type pin_s;
  logic [7:0]    l3, l4, v, c, e2, e3, e4, ev;

  // =========================================================================
  // instances
  peripheral_irq_enable_flags DUT (.clk_i(clk), .rstn_i(rstn), .bus_i(bus), .rdata_o(rdata),
    .timer0_ovf_i(t0), .ext_pin_i(ext), .port_pins_i(pins), .req2_events_i(ev2),
    .req3_flags_i(lv3), .req4_flags_i(lv4), .irq_o(irq));
  periph_model model (.clk_i(clk), .t0_ovf_o(t0), .ext_pin_o(ext), .pins_o(pins),
    .ev2_o(ev2), .lvl3_o(lv3), .lvl4_o(lv4));

  // 250 MHz clock
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // hang guard, the tests need a few hundred cycles
  initial cycles = 0;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end

  // =========================================================================
  // bus cycles and compares
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{rd: 1'h0, wr: 1'h1, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic chk_reg(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{rd: 1'h1, wr: 1'h0, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus <= '0;
    #1 total_checks++;
    if (rdata !== e) begin
      mismatches++;
      $display("Error reg %h expected %h seen %h", a, e, rdata);
    end
  endtask

  task automatic chk_irq(input logic e);
    total_checks++;
    if (irq !== e) begin
      mismatches++;
      $display("Error irq expected %b seen %b", e, irq);
    end
  endtask

  // register-0 timer source needs only global enable, the rest also peripheral
  function automatic logic exp_irq(input logic [7:0] c, input logic t, input logic [23:0] ef, input logic [23:0] rf);
    return c[7] & (t | (c[6] & |(ef & rf)));
  endfunction

  task automatic done(input string n);
    $display("test %s done", n);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // =========================================================================
  // main sequence
  initial begin
    bus = '0;
    rstn = 1'h0;
    mismatches = 0;
    total_checks = 0;
    ext_s = 1'h0;
    pin_s = '0;
    l3 = 8'h00;
    l4 = 8'h00;
    void'($urandom(87884));
    repeat (20) @(posedge clk);
    rstn <= 1'h1;
    for (int a = 0; a < 8; a++) chk_reg(5'(a), (a == 0) ? CTRL_RESET : REG_RESET);
    done("reset");
    // all ones, all zeros, then random on enable registers 2, 3 and 4
    for (int i = 0; i < 9; i++) begin
      v = (i < 3) ? 8'hFF : (i < 6) ? 8'h00 : 8'($urandom);
      wr(ADDR_EN2 + 5'(i % 3), v);
      chk_reg(ADDR_EN2 + 5'(i % 3), v);
    end
    wr(ADDR_EN0, 8'hFF);
    chk_reg(ADDR_EN0, 8'h31);
    done("enables");
    model.pulse(1'h1, 8'h00);
    chk_reg(ADDR_REQ0, 8'h20);
    chk_irq(1'h0);
    wr(ADDR_REQ0, 8'hFF);
    chk_reg(ADDR_REQ0, 8'h21);
    wr(ADDR_REQ0, 8'h00);
    chk_reg(ADDR_REQ0, 8'h00);
    done("timer0");
    // rise with select 1, fall with select 0, then a rise that must not count
    for (int i = 0; i < 3; i++) begin
      ext_s = (i != 1);
      model.drive(ext_s, pin_s, l3, l4);
      repeat (6) @(posedge clk);
      chk_reg(ADDR_REQ0, (i < 2) ? 8'h01 : 8'h00);
      wr(ADDR_REQ0, 8'h00);
      wr(ADDR_CTRL, 8'h00);
    end
    done("ext pin");
    wr(5'h08, 8'h01);
    wr(5'h0D, 8'h80);
    chk_reg(5'h08, 8'h01);
    chk_reg(5'h0D, 8'h80);
    pin_s[0] = 8'h03;
    pin_s[1] = 8'h80;
    model.drive(ext_s, pin_s, l3, l4);
    repeat (6) @(posedge clk);
    chk_reg(5'h10, 8'h01);
    chk_reg(5'h11, 8'h00);
    chk_reg(ADDR_REQ0, 8'h10);
    pin_s[1] = 8'h00;
    model.drive(ext_s, pin_s, l3, l4);
    repeat (6) @(posedge clk);
    chk_reg(5'h11, 8'h80);
    wr(ADDR_REQ0, 8'h00);
    chk_reg(ADDR_REQ0, 8'h10);
    wr(5'h10, 8'h00);
    chk_reg(ADDR_REQ0, 8'h10);
    wr(5'h11, 8'h00);
    chk_reg(ADDR_REQ0, 8'h00);
    done("pin change");
    // first passes pin peripheral enable on and off, then events with both control enables and enable register 2 clear
    for (int i = 0; i < 12; i++) begin
      c = (i == 0) ? 8'hC0 : (i == 1) ? 8'h80 : (i == 2) ? 8'h00 : {2'($urandom), 6'h00};
      e2 = (i == 2) ? 8'h00 : 8'($urandom);
      e3 = 8'($urandom);
      e4 = 8'($urandom);
      l3 = 8'($urandom);
      l4 = 8'($urandom);
      ev = (i == 2) ? 8'hFF : 8'($urandom);
      t0b = 1'($urandom);
      wr(ADDR_REQ0, 8'h00);
      wr(ADDR_REQ2, 8'h00);
      wr(ADDR_EN0, 8'h20);
      wr(ADDR_EN2, e2);
      wr(ADDR_EN3, e3);
      wr(ADDR_EN4, e4);
      wr(ADDR_CTRL, c);
      model.pulse(t0b, ev);
      model.drive(ext_s, pin_s, l3, l4);
      repeat (3) @(posedge clk);
      #1 chk_irq(exp_irq(c, t0b, {e2, e3, e4}, {ev, l3, l4}));
      chk_reg(ADDR_REQ2, ev);
    end
    done("irq");
    final_report();
  end
endmodule // peripheral_irq_enable_flags_bench
